/* logic/fnm_pkg.sv */
// Purpose: constants and types for the fractional-N modulator, slip reduction and fast-lock control
// Assumes: one 100 MHz system clock; reference and comparison edges sampled synchronously
// Notes: register index is the three-bit reg_sel pattern; readback of registers one, three and status echoes it in the low bits of the word
//
// What this block does and what the host must keep
// [RULE1] Doubler presents twice the reference rate
// [RULE2] Host keeps comparison rate at most 32 MHz
// [RULE3] Halver divides reference by two, 50% duty
// [RULE4] Modulus is 12 bits, range 2..4095
// [RULE5] Host keeps modulus at least 50 dithered
// [RULE6] Third-order modulator steps once per comparison
// [RULE7] Undithered repeat length follows modulus divisibility
// [RULE8] Dithered repeat length is two to 21
// [RULE9] Imminent slip enables one directed extra cell
// [RULE10] Each further slip adds one, seven max
// [RULE11] Past target, cells turn off one by one
// [RULE12] Bit 18 of register three enables slip reduction
// [RULE13] Host keeps detector duty within 45..55%
// [RULE14] Mode field 0,1 selects fast-lock, loads timer
// [RULE15] Host initialises, then writes register three
// [RULE16] Wide interval lasts timer times modulus cycles
// [RULE17] Wide interval raises pump current sixteenfold
// [RULE18] Switch pin grounded during wide interval
// [RULE19] Mode 1,0 resync; mode 0,0 timer off
// [RULE20] Select bits 0,1,1 route word to register three
// [RULE21] Expiry restores current and releases switch pin
// [RULE22] New fast-lock write restarts timer fully
package fnm_pkg;
   localparam int DATA_W = 32;
   localparam logic [2:0] SEL_REG1 = 3'h1;
   localparam logic [2:0] SEL_REG2 = 3'h2;
   localparam logic [2:0] SEL_REG3 = 3'h3;
   localparam logic [2:0] SEL_STAT = 3'h7;
   // Register one: fraction and modulus
   localparam int FRAC_LSB = 15;
   localparam int MODU_LSB = 3;
   // Register two: reference options and pump setting
   localparam int DBL_BIT = 25;
   localparam int HALF_BIT = 24;
   localparam int DITH_BIT = 23;
   localparam int CP_LSB = 9;
   // Register three
   localparam int SLIP_EN_BIT = 18;
   localparam int CDM_LSB = 15;
   localparam int CDV_LSB = 3;
   localparam logic [1:0] CDM_OFF = 2'h0;
   localparam logic [1:0] CDM_FAST = 2'h1;
   localparam logic [1:0] CDM_RESYNC = 2'h2;
   localparam logic [11:0] MODU_MIN = 12'h002;
   localparam logic [11:0] MODU_RST = 12'h002;
   localparam logic [2:0] CELLS_MAX = 3'h7;
   localparam logic [7:0] CP_BOOST_SHIFT = 8'h04;
   localparam logic [20:0] LFSR_SEED = 21'h000001;
   localparam logic [20:0] LFSR_TAPS = 21'h140000;
   localparam logic [2:0] STAGE_NUM = 3'h3;
   typedef struct packed {
      logic [2:0] sel;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } fnm_bus_t;
   typedef struct packed {
      logic [11:0] modulus;
      logic [11:0] frac;
      logic dbl;
      logic half;
      logic dither;
      logic [3:0] cp;
      logic slip_en;
      logic [1:0] cdm;
      logic [11:0] cdv;
   } fnm_cfg_t;
   typedef enum {FL_IDLE, FL_WIDE, FL_RESYNC} fnm_fl_t;
endpackage

/* logic/fnm_top.sv */
// Purpose: modulator, reference conditioning, slip reduction and fast-lock control
// Assumes: all inputs synchronous to clk; comparison strobe at most one per cycle
// Notes: read data valid the cycle after the read strobe only
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fnm_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic reference_input,
   input wire logic cmp_tick,
   input wire logic slip_near,
   input wire logic slip_up,
   input wire logic target_passed,
   output logic pfd_ref,
   output logic [2:0] extra_cells,
   output logic extra_dir_up,
   output logic [7:0] cp_current,
   output logic fastlock_switch_pin_o,
   output logic fastlock_switch_pin_oe,
   output logic [3:0] mod_step
);
   ////////////////////////////////////////////////////////////////////////
   fnm_pkg::fnm_bus_t bus;
   fnm_pkg::fnm_cfg_t cfg_r;
   logic new_fast;
   assign bus = '{sel: reg_sel, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign new_fast = bus.wr && bus.sel == fnm_pkg::SEL_REG3
      && bus.wdata[fnm_pkg::CDM_LSB +: 2] == fnm_pkg::CDM_FAST;

   function automatic logic [11:0] clamp_mod(input logic [11:0] v);
      clamp_mod = (v < fnm_pkg::MODU_MIN) ? fnm_pkg::MODU_MIN : v;
   endfunction

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r <= '{modulus: fnm_pkg::MODU_RST, default: '0};
      end else if (bus.wr) begin
         case (bus.sel)
            fnm_pkg::SEL_REG1: begin
               cfg_r.modulus <= clamp_mod(bus.wdata[fnm_pkg::MODU_LSB +: 12]); // RULE4
               cfg_r.frac <= bus.wdata[fnm_pkg::FRAC_LSB +: 12];
            end
            fnm_pkg::SEL_REG2: begin
               cfg_r.dbl <= bus.wdata[fnm_pkg::DBL_BIT];
               cfg_r.half <= bus.wdata[fnm_pkg::HALF_BIT];
               cfg_r.dither <= bus.wdata[fnm_pkg::DITH_BIT];
               cfg_r.cp <= bus.wdata[fnm_pkg::CP_LSB +: 4];
            end
            fnm_pkg::SEL_REG3: begin // RULE20
               cfg_r.slip_en <= bus.wdata[fnm_pkg::SLIP_EN_BIT]; // RULE12
               cfg_r.cdm <= bus.wdata[fnm_pkg::CDM_LSB +: 2]; // RULE14 RULE19
               cfg_r.cdv <= bus.wdata[fnm_pkg::CDV_LSB +: 12];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference conditioning: doubler emits a pulse on both edges
   logic ref_d_r, half_r, pfd_r;
   logic ref_rise, ref_edge;
   assign ref_rise = reference_input && !ref_d_r;
   assign ref_edge = reference_input ^ ref_d_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_d_r <= 1'b0;
         half_r <= 1'b0;
         pfd_r <= 1'b0;
      end else begin
         ref_d_r <= reference_input;
         if (ref_rise) begin
            half_r <= !half_r; // RULE3
         end
         if (cfg_r.half) begin
            pfd_r <= half_r ^ ref_rise; // RULE3
         end else if (cfg_r.dbl) begin
            pfd_r <= ref_edge; // RULE1
         end else begin
            pfd_r <= reference_input;
         end
      end
   end
   assign pfd_ref = pfd_r;

   ////////////////////////////////////////////////////////////////////////
   // Third-order MASH modulator; each stage wraps at the modulus
   logic [11:0] acc_r [3];
   logic [2:0] carry;
   logic [11:0] acc_in [3];
   logic [12:0] acc_sum [3];
   logic [20:0] lfsr_r;
   logic [11:0] seed;
   assign seed = {11'h000, cfg_r.dither & lfsr_r[0]}; // RULE8
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_stage
         if (g == 0) begin : g_first
            assign acc_in[g] = cfg_r.frac;
         end else begin : g_next
            assign acc_in[g] = acc_r[g-1];
         end
         assign acc_sum[g] = {1'b0, acc_r[g]} + {1'b0, acc_in[g]} + ((g == 2) ? {1'b0, seed} : 13'h0000);
         assign carry[g] = acc_sum[g] >= {1'b0, cfg_r.modulus};
         always_ff @(posedge clk) begin
            if (sys_rst || new_fast) begin
               acc_r[g] <= 12'h000;
            end else if (cmp_tick) begin // RULE6
               acc_r[g] <= carry[g] ? 12'(acc_sum[g] - {1'b0, cfg_r.modulus}) : acc_sum[g][11:0];
            end
         end
      end
   endgenerate

   // Noise shaping: c1 + dc2 + d2c3; repeat length set by the modulus arithmetic, RULE7
   logic c2_d_r, c3_d_r, c3_dd_r;
   logic [3:0] step_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         c2_d_r <= 1'b0;
         c3_d_r <= 1'b0;
         c3_dd_r <= 1'b0;
         step_r <= 4'h0;
         lfsr_r <= fnm_pkg::LFSR_SEED;
      end else if (cmp_tick) begin // RULE6 RULE7
         c2_d_r <= carry[1];
         c3_d_r <= carry[2];
         c3_dd_r <= c3_d_r;
         step_r <= 4'(4'sd4 + $signed({3'h0, carry[0]}) + $signed({3'h0, carry[1]})
            - $signed({3'h0, c2_d_r}) + $signed({3'h0, carry[2]})
            - $signed({2'h0, c3_d_r, 1'b0}) + $signed({3'h0, c3_dd_r}));
         lfsr_r <= {lfsr_r[19:0], ^(lfsr_r & fnm_pkg::LFSR_TAPS)}; // RULE8
      end
   end
   assign mod_step = step_r;

   ////////////////////////////////////////////////////////////////////////
   // Slip reduction cell counter
   logic [2:0] cells_r;
   logic dir_r, falling_r;
   always_ff @(posedge clk) begin
      if (sys_rst || !cfg_r.slip_en) begin // RULE12
         cells_r <= 3'h0;
         dir_r <= 1'b0;
         falling_r <= 1'b0;
      end else if (cmp_tick) begin
         if (target_passed && cells_r != 3'h0) begin
            falling_r <= 1'b1; // RULE11
         end
         if (falling_r || (target_passed && cells_r != 3'h0)) begin
            cells_r <= (cells_r != 3'h0) ? cells_r - 3'h1 : 3'h0; // RULE11
            if (cells_r <= 3'h1) begin
               falling_r <= 1'b0;
            end
         end else if (slip_near && cells_r != fnm_pkg::CELLS_MAX) begin
            cells_r <= cells_r + 3'h1; // RULE9 RULE10
            if (cells_r == 3'h0) begin
               dir_r <= slip_up; // RULE9
            end
         end
      end
   end
   assign extra_cells = cells_r;
   assign extra_dir_up = dir_r;

   ////////////////////////////////////////////////////////////////////////
   // Fast-lock timer: value times modulus comparison cycles
   fnm_pkg::fnm_fl_t fl_r;
   logic [11:0] outer_r, inner_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fl_r <= fnm_pkg::FL_IDLE;
         outer_r <= 12'h000;
         inner_r <= 12'h000;
      end else if (bus.wr && bus.sel == fnm_pkg::SEL_REG3) begin
         fl_r <= fnm_pkg::FL_IDLE; // RULE19
         if (new_fast && bus.wdata[fnm_pkg::CDV_LSB +: 12] != 12'h000) begin
            fl_r <= fnm_pkg::FL_WIDE; // RULE14 RULE22
            outer_r <= bus.wdata[fnm_pkg::CDV_LSB +: 12];
            inner_r <= cfg_r.modulus;
         end else if (bus.wdata[fnm_pkg::CDM_LSB +: 2] == fnm_pkg::CDM_RESYNC) begin
            fl_r <= fnm_pkg::FL_RESYNC; // RULE19
         end
      end else begin
         case (fl_r)
            fnm_pkg::FL_WIDE: begin
               if (cmp_tick) begin // RULE16
                  if (inner_r > 12'h001) begin
                     inner_r <= inner_r - 12'h001;
                  end else if (outer_r > 12'h001) begin
                     outer_r <= outer_r - 12'h001;
                     inner_r <= cfg_r.modulus;
                  end else begin
                     fl_r <= fnm_pkg::FL_IDLE; // RULE21
                  end
               end
            end
            fnm_pkg::FL_IDLE, fnm_pkg::FL_RESYNC: begin
            end
            default: fl_r <= fnm_pkg::FL_IDLE;
         endcase
      end
   end

   logic [7:0] cp_r;
   logic sw_oe_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cp_r <= 8'h00;
         sw_oe_r <= 1'b0;
      end else begin
         cp_r <= (fl_r == fnm_pkg::FL_WIDE) ? ({4'h0, cfg_r.cp} << fnm_pkg::CP_BOOST_SHIFT) // RULE17
            : {4'h0, cfg_r.cp}; // RULE21
         sw_oe_r <= fl_r == fnm_pkg::FL_WIDE; // RULE18 RULE21
      end
   end
   assign cp_current = cp_r;
   assign fastlock_switch_pin_oe = sw_oe_r;
   assign fastlock_switch_pin_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Readback; status word shows live block state
   logic [31:0] rdata_r;
   always_ff @(posedge clk) begin
      if (sys_rst || !bus.rd) begin
         rdata_r <= 32'h00000000;
      end else begin
         case (bus.sel)
            fnm_pkg::SEL_REG1: rdata_r <= {5'h00, cfg_r.frac, cfg_r.modulus, fnm_pkg::SEL_REG1};
            fnm_pkg::SEL_REG3: rdata_r <= {13'h0000, cfg_r.slip_en, 1'b0, cfg_r.cdm, cfg_r.cdv, fnm_pkg::SEL_REG3};
            fnm_pkg::SEL_STAT: rdata_r <= {8'h00, outer_r, cells_r, dir_r, 3'h0, sw_oe_r, 1'b0, fnm_pkg::SEL_STAT};
            default: rdata_r <= 32'h00000000;
         endcase
      end
   end
   assign reg_rdata = rdata_r;
endmodule // fnm_top
`default_nettype wire

/* sim/fnm_top_assertions.sv */
// Purpose: port-level properties of fnm_top
// Assumes: one clock, sys_rst synchronous active high
// Notes: pump setting and slip enable mirrored from writes
`timescale 1ns/1ps
`default_nettype none
module fnm_top_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [2:0] extra_cells,
   input wire logic [7:0] cp_current,
   input wire logic fastlock_switch_pin_o,
   input wire logic fastlock_switch_pin_oe
);
   logic [3:0] cp_r;
   logic slip_r;
   wire logic r3_wr = reg_wr && reg_sel == 3'h3;
   wire logic fl_wr = r3_wr && reg_wdata[16:15] == fnm_pkg::CDM_FAST && reg_wdata[14:3] != 12'h000;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cp_r <= 4'h0;
         slip_r <= 1'b0;
      end else begin
         if (reg_wr && reg_sel == 3'h2) cp_r <= reg_wdata[12:9];
         if (r3_wr) slip_r <= reg_wdata[18];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_fl_start; fl_wr |-> ##2 fastlock_switch_pin_oe && !fastlock_switch_pin_o; endproperty
   a_fl_start: assert property (p_fl_start) else $error("switch pin not grounded");
   property p_fl_only; $rose(fastlock_switch_pin_oe) |-> $past(fl_wr, 2); endproperty
   a_fl_only: assert property (p_fl_only) else $error("wide interval without write");
   property p_mode_off; r3_wr && reg_wdata[16:15] != fnm_pkg::CDM_FAST |-> ##2 !fastlock_switch_pin_oe; endproperty
   a_mode_off: assert property (p_mode_off) else $error("wide interval not stopped");
   property p_boost; fastlock_switch_pin_oe && cp_r == $past(cp_r) |-> cp_current == {cp_r, 4'h0}; endproperty
   a_boost: assert property (p_boost) else $error("pump current not boosted");
   property p_cell_up; extra_cells > $past(extra_cells) |-> extra_cells == $past(extra_cells) + 3'h1; endproperty
   a_cell_up: assert property (p_cell_up) else $error("cells jumped up");
   property p_cell_down;
      slip_r && $past(slip_r) && extra_cells < $past(extra_cells) |-> $past(extra_cells) - extra_cells == 3'h1;
   endproperty
   a_cell_down: assert property (p_cell_down) else $error("cells dropped more than one");
   property p_slip_off; !slip_r && !$past(slip_r) |-> extra_cells == 3'h0; endproperty
   a_slip_off: assert property (p_slip_off) else $error("cells on while disabled");
   c_fl_end: cover property ($fell(fastlock_switch_pin_oe));
   c_cells_max: cover property (extra_cells == 3'h7);
   c_restart: cover property (fl_wr && fastlock_switch_pin_oe);
endmodule // fnm_top_assertions
bind fnm_top fnm_top_assertions i_fnm_top_assertions (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .extra_cells(extra_cells),
   .cp_current(cp_current), .fastlock_switch_pin_o(fastlock_switch_pin_o),
   .fastlock_switch_pin_oe(fastlock_switch_pin_oe));
`default_nettype wire

/* sim/fnm_ref_src.sv */
// Purpose: reference source feeding the detector side
// Assumes: free-running oscillator, ticks only while run is high
// Notes: four-cycle period gives 25 MHz at 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module fnm_ref_src (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic reference_input,
   output logic cmp_tick
);
   logic [1:0] ph_r;
   // Square wave keeps the rate under the limit and duty at half
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph_r <= 2'h0;
         reference_input <= 1'b0;
         cmp_tick <= 1'b0;
      end else begin
         ph_r <= ph_r + 2'h1;
         reference_input <= ph_r[1];
         cmp_tick <= run && ph_r == 2'h3;
      end
   end
endmodule // fnm_ref_src
`default_nettype wire

/* sim/fnm_top_test.sv */
// Purpose: self-checking bench for fnm_top
// Assumes: reads answered one cycle after the strobe
// Notes: status reads are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module fnm_top_test;
   logic clk, sys_rst, reg_wr, reg_rd, run, slip_near, slip_up, target_passed, rd_d, p;
   logic reference_input, cmp_tick, pfd_ref, extra_dir_up, sw_o, sw_oe;
   logic [2:0] reg_sel, extra_cells;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0] cp_current;
   logic [3:0] mod_step, cp;
   logic [31:0] exp_q[$], msk_q[$];
   logic [3:0] seq[$];
   int failures, tests_run, v, m, n, e;
   int ml[4] = '{5, 4, 3, 6};
   fnm_top i_fnm_top (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_input(reference_input), .cmp_tick(cmp_tick),
      .slip_near(slip_near), .slip_up(slip_up), .target_passed(target_passed), .pfd_ref(pfd_ref),
      .extra_cells(extra_cells), .extra_dir_up(extra_dir_up), .cp_current(cp_current),
      .fastlock_switch_pin_o(sw_o), .fastlock_switch_pin_oe(sw_oe), .mod_step(mod_step));
   fnm_ref_src i_fnm_ref_src (.clk(clk), .sys_rst(sys_rst), .run(run), .reference_input(reference_input),
      .cmp_tick(cmp_tick));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic end_sim;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [2:0] s, input logic [31:0] d);
      reg_sel <= s;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] s, input logic [31:0] expv, input logic [31:0] msk);
      exp_q.push_back(expv);
      msk_q.push_back(msk);
      reg_sel <= s;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic tick(input int k);
      run <= 1'b1;
      repeat (k) @(posedge clk iff cmp_tick);
      run <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fl(input int t);
      wr(3'h3, (32'h1 << fnm_pkg::CDM_LSB) | (32'(t) << fnm_pkg::CDV_LSB));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (rd_d) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
      rd_d <= reg_rd;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, run, slip_near, slip_up, target_passed, rd_d} = 8'h80;
      reg_sel = 3'h0;
      reg_wdata = 32'h0;
      v = $urandom(32'h467e17bc);
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int s = 0; s < 7; s++) if (s == 0 || s > 3) begin
         wr(3'(s), 32'hFFFFFFFF);
         rd(3'(s), 32'h0, 32'hFFFFFFFF);
      end
      rd(3'h7, 32'h0, 32'h00000F10);
      // Rising edges of the conditioned reference over 64 cycles
      for (int k = 0; k < 3; k++) begin
         wr(3'h2, 32'(k) << fnm_pkg::HALF_BIT);
         repeat (4) @(posedge clk);
         n = 0;
         p = pfd_ref;
         repeat (64) begin
            @(posedge clk);
            n += int'(pfd_ref && !p);
            p = pfd_ref;
         end
         e = (k == 1) ? 8 : (k == 2) ? 32 : 16;
         check(32'(n >= e - 1 && n <= e + 1), 32'h1);
      end
      cp = 4'($urandom_range(15, 1));
      v = $urandom_range(3, 1);
      m = 3;
      wr(3'h2, 32'(cp) << fnm_pkg::CP_LSB);
      wr(3'h1, 32'(m) << fnm_pkg::MODU_LSB);
      fl(v);
      tick(v * m - 1);
      check(32'(sw_oe), 32'h1);
      check(32'(cp_current), 32'({cp, 4'h0}));
      fl(v);
      tick(v * m - 1);
      check(32'(sw_oe), 32'h1);
      tick(1);
      repeat (3) @(posedge clk);
      check(32'(sw_oe), 32'h0);
      check(32'(cp_current), 32'(cp));
      for (int md = 0; md < 3; md += 2) begin
         fl(1);
         wr(3'h3, 32'(md) << fnm_pkg::CDM_LSB);
         repeat (2) @(posedge clk);
         check(32'(sw_oe), 32'h0);
      end
      wr(3'h3, 32'h1 << fnm_pkg::SLIP_EN_BIT);
      slip_up <= 1'($urandom);
      slip_near <= 1'b1;
      tick(1);
      check(32'(extra_dir_up), 32'(slip_up));
      rd(3'h7, 32'h200 | (32'(slip_up) << 8), 32'hF00);
      tick(8);
      rd(3'h7, 32'hE00 | (32'(slip_up) << 8), 32'hF00);
      slip_near <= 1'b0;
      target_passed <= 1'b1;
      tick(7);
      rd(3'h7, 32'h0, 32'hE00);
      slip_near <= 1'b1;
      target_passed <= 1'b0;
      tick(2);
      wr(3'h3, 32'h0);
      tick(2);
      rd(3'h7, 32'h0, 32'hE00);
      slip_near <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         m = ml[i];
         n = m * ((m % 6 == 0) ? 6 : (m % 3 == 0) ? 3 : (m % 2 == 0) ? 2 : 1);
         wr(3'h1, (32'h1 << fnm_pkg::FRAC_LSB) | (32'(m) << fnm_pkg::MODU_LSB));
         fl(1);
         seq.delete();
         run <= 1'b1;
         repeat (3 * n) begin
            @(posedge clk iff cmp_tick);
            repeat (2) @(posedge clk);
            seq.push_back(mod_step);
         end
         run <= 1'b0;
         @(posedge clk);
         for (int j = n; j < 2 * n; j++) check(32'(seq[j]), 32'(seq[j + n]));
      end
      // Dithered: the undithered period must no longer repeat
      wr(3'h2, 32'h1 << fnm_pkg::DITH_BIT);
      m = 50;
      n = 2 * m;
      wr(3'h1, (32'h1 << fnm_pkg::FRAC_LSB) | (32'(m) << fnm_pkg::MODU_LSB));
      fl(1);
      seq.delete();
      run <= 1'b1;
      repeat (3 * n) begin
         @(posedge clk iff cmp_tick);
         repeat (2) @(posedge clk);
         seq.push_back(mod_step);
      end
      run <= 1'b0;
      @(posedge clk);
      e = 0;
      for (int j = n; j < 2 * n; j++) e += int'(seq[j] != seq[j + n]);
      check(32'(e > 0), 32'h1);
      end_sim();
   end
endmodule // fnm_top_test
`default_nettype wire
